// ---- ssr_chk.sv ----
/*
  ssr_chk: port assertions for the self refresh control block.
  assumes: bound to ssr_self_refresh_ctrl, one sys_clk domain.
*/
`timescale 1ns/10ps
module ssr_chk
#(
  parameter int DIV = 4
) (
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  input wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       mem_access_req,
  input wire logic                       mem_access_served,
  input wire logic                       mem_access_ready,
  input wire logic                       sr_enter_cmd,
  input wire logic                       sr_exit_cmd,
  input wire logic                       sr_active
);
  import ssr_pkg::*;
  localparam logic [7:0] MIN_IDLE = 8'(2 * DIV - 1);
  logic [7:0] idle_cyc;
  wire        ctrl_wr = reg_wr && reg_addr == CTRL_OFFSET;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // idle cycles since the last access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) idle_cyc <= 8'h00;
    else if (mem_access_req || mem_access_served) idle_cyc <= 8'h00;
    else if (idle_cyc != 8'hff) idle_cyc <= idle_cyc + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_enter;
    ctrl_wr && reg_wdata[SR_ENABLE_BIT] && !sr_active |=> sr_enter_cmd && sr_active;
  endproperty
  a_enter: assert property (p_enter) else $error("no entry after enable write");
  property p_pulse; sr_enter_cmd |=> !sr_enter_cmd && !sr_exit_cmd; endproperty
  a_pulse: assert property (p_pulse) else $error("entry pulse too long");
  property p_exit;
    ctrl_wr && !reg_wdata[SR_ENABLE_BIT] && sr_active |=> sr_exit_cmd && !sr_active;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit after disable write");
  property p_rd_wo;
    reg_rd && reg_addr == CTRL_OFFSET |=> reg_rdata[SR_ENABLE_BIT] == 1'b0;
  endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("enable bit reads back");
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_wake;
    !reg_wr && mem_access_req && sr_active |=> sr_exit_cmd ##1 mem_access_ready;
  endproperty
  a_wake: assert property (p_wake) else $error("access did not wake sdram");
  property p_busy; sr_active |-> !mem_access_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready while in self refresh");
  property p_auto; sr_enter_cmd && !$past(reg_wr) |-> idle_cyc >= MIN_IDLE; endproperty
  a_auto: assert property (p_auto) else $error("re-entry before idle count");
endmodule : ssr_chk

// ---- ssr_pkg.sv ----
/*
  ssr_pkg: constants and types for the sdram self refresh control block.
  assumes: 16-bit register port, memory clock equal to sys_clk.
*/
package ssr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 16;
  localparam logic [15:0] CTRL_OFFSET     = 16'h1c08;
  localparam logic [15:0] STATUS_OFFSET   = 16'h1c0c;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int          SR_ENABLE_BIT   = 0;
  localparam int          REENTRY_BIT     = 1;
  localparam int          RSV2_BIT        = 2;
  localparam int          RSV_LO_LSB      = 3;
  localparam int          RSV_LO_MSB      = 6;
  localparam int          IDLE_LSB        = 8;
  localparam int          IDLE_MSB        = 15;

  ////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int          ST_SR_BIT       = 0;
  localparam int          ST_WOKEN_BIT    = 1;
  localparam int          ST_CNT_LSB      = 8;
  localparam int          ST_CNT_MSB      = 15;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic        REENTRY_RST     = 1'b0;
  localparam logic        RSV2_RST        = 1'b0;
  localparam logic [3:0]  RSV_LO_RST      = 4'h3;
  localparam logic [7:0]  IDLE_RST        = 8'h0f;
  localparam logic [7:0]  IDLE_MIN        = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // timing: idle count tick is one quarter of the memory clock
  localparam int          TICK_DIV        = 4;

  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [1:0] {
    SSR_AWAKE = 2'b00,
    SSR_SELF  = 2'b01,
    SSR_WOKEN = 2'b10
  } ssr_state_t;

endpackage : ssr_pkg

// ---- ssr_sdram_model.sv ----
/*
  ssr_sdram_model: sdram side, tracks self refresh and makes accesses.
  assumes: go pulse from the bench starts one access.
*/
`timescale 1ns/10ps
module ssr_sdram_model (
  input  wire logic sys_clk,
  input  wire logic go,
  input  wire logic mem_access_ready,
  input  wire logic sr_enter_cmd,
  input  wire logic sr_exit_cmd,
  output logic      mem_access_req,
  output logic      mem_access_served,
  output logic      in_sr,
  output logic      bad
);
  initial begin
    mem_access_req = 1'b0;
    mem_access_served = 1'b0;
    in_sr = 1'b0;
    bad = 1'b0;
  end
  // access held until ready, then one served pulse
  always @(posedge sys_clk) begin
    mem_access_served <= 1'b0;
    if (go) mem_access_req <= 1'b1;
    if (mem_access_req && mem_access_ready) begin
      mem_access_req <= 1'b0;
      mem_access_served <= 1'b1;
    end
    if (sr_enter_cmd) begin
      bad <= bad | in_sr;
      in_sr <= 1'b1;
    end
    if (sr_exit_cmd) begin
      bad <= bad | !in_sr;
      in_sr <= 1'b0;
    end
  end
endmodule : ssr_sdram_model

// ---- ssr_self_refresh_ctrl.sv ----
/*
  ssr_self_refresh_ctrl: self refresh entry, exit and automatic re-entry
  for an external sdram, with its control and status registers.
  assumes: a command sequencer that issues the sdram commands on the
  enter and exit pulses; access request and served strobes on sys_clk.
*/
// Our own choice: the plain strobed port.
// Functional notes
// - writing one to enable bit enters self refresh
// - writing zero exits; reset leaves sdram awake
// - enable bit is write-only, reads zero
// - re-entry bit allows return after access wake
// - idle count elapses, quarter clock, min two
// - reserved bit two resets zero, no effect
`timescale 1ns/10ps
module ssr_self_refresh_ctrl
#(
  parameter int DIV = ssr_pkg::TICK_DIV
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ssr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      mem_access_req,
  input  wire logic                      mem_access_served,
  output logic                           mem_access_ready,
  output logic                           sr_enter_cmd,
  output logic                           sr_exit_cmd,
  output logic                           sr_active
);
  import ssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire ctrl_sel   = (reg_addr == CTRL_OFFSET);
  wire status_sel = (reg_addr == STATUS_OFFSET);
  wire ctrl_wr    = reg_wr && ctrl_sel;

  wire       wr_sr_bit   = reg_wdata[SR_ENABLE_BIT];
  wire       wr_enter    = ctrl_wr && wr_sr_bit;
  wire       wr_exit     = ctrl_wr && !wr_sr_bit;
  wire [7:0] wr_idle_raw = reg_wdata[IDLE_MSB:IDLE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // control register storage

  logic       reentry_en;
  logic       rsv2;
  logic [3:0] rsv_lo;
  logic [7:0] idle_reload;

  logic       next_reentry_en;
  logic       next_rsv2;
  logic [3:0] next_rsv_lo;
  logic [7:0] next_idle_reload;

  // values below the minimum are raised to it
  wire [7:0] wr_idle_clamped = (wr_idle_raw < IDLE_MIN) ? IDLE_MIN : wr_idle_raw;

  assign next_reentry_en  = ctrl_wr ? reg_wdata[REENTRY_BIT] : reentry_en;
  // reserved bits hold their value only for readback
  assign next_rsv2        = ctrl_wr ? reg_wdata[RSV2_BIT] : rsv2;
  assign next_rsv_lo      = ctrl_wr ? reg_wdata[RSV_LO_MSB:RSV_LO_LSB] : rsv_lo;
  assign next_idle_reload = ctrl_wr ? wr_idle_clamped : idle_reload;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reentry_en  <= REENTRY_RST;
      rsv2        <= RSV2_RST;
      rsv_lo      <= RSV_LO_RST;
      idle_reload <= IDLE_RST;
    end else begin
      reentry_en  <= next_reentry_en;
      rsv2        <= next_rsv2;
      rsv_lo      <= next_rsv_lo;
      idle_reload <= next_idle_reload;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle tick at one quarter of the memory clock

  logic      idle_tick;
  ssr_state_t state;
  ssr_state_t next_state;

  wire access_seen = mem_access_req || mem_access_served;
  wire tick_restart = (state != SSR_WOKEN) || access_seen;

  ssr_tick_div #(
    .DIV     (DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (tick_restart),
    .tick    (idle_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // idle counter

  logic [7:0] idle_cnt;
  logic [7:0] next_idle_cnt;

  wire idle_done = (idle_cnt == 8'h00);
  wire cnt_load  = (state != SSR_WOKEN) || access_seen;

  assign next_idle_cnt = cnt_load ? idle_reload :
                         (idle_tick && !idle_done) ? idle_cnt - 8'h01 :
                         idle_cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= IDLE_RST;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self refresh state machine

  logic next_enter;
  logic next_exit;

  wire reentry_due = reentry_en && idle_done && !access_seen;

  always_comb begin
    next_state = state;
    next_enter = 1'b0;
    next_exit  = 1'b0;
    unique case (state)
      SSR_AWAKE: begin
        if (wr_enter) begin
          next_state = SSR_SELF;
          next_enter = 1'b1;
        end
      end
      SSR_SELF: begin
        if (wr_exit) begin
          next_state = SSR_AWAKE;
          next_exit  = 1'b1;
        end else if (mem_access_req) begin
          // wake for the access; keep awake unless re-entry is on
          next_state = next_reentry_en ? SSR_WOKEN : SSR_AWAKE;
          next_exit  = 1'b1;
        end
      end
      SSR_WOKEN: begin
        if (wr_exit) begin
          next_state = SSR_AWAKE;
        end else if (wr_enter) begin
          next_state = SSR_SELF;
          next_enter = 1'b1;
        end else if (!reentry_en) begin
          next_state = SSR_AWAKE;
        end else if (reentry_due) begin
          next_state = SSR_SELF;
          next_enter = 1'b1;
        end
      end
      default: begin
        next_state = SSR_AWAKE;
      end
    endcase
  end

  wire next_sr_active = (next_state == SSR_SELF);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= SSR_AWAKE;
      sr_enter_cmd <= 1'b0;
      sr_exit_cmd  <= 1'b0;
      sr_active    <= 1'b0;
    end else begin
      state        <= next_state;
      sr_enter_cmd <= next_enter;
      sr_exit_cmd  <= next_exit;
      sr_active    <= next_sr_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory side outputs

  assign mem_access_ready = (state != SSR_SELF) && !sr_exit_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // read back

  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    ctrl_view                        = '0;
    ctrl_view[SR_ENABLE_BIT]         = 1'b0;
    ctrl_view[REENTRY_BIT]           = reentry_en;
    ctrl_view[RSV2_BIT]              = rsv2;
    ctrl_view[RSV_LO_MSB:RSV_LO_LSB] = rsv_lo;
    ctrl_view[IDLE_MSB:IDLE_LSB]     = idle_reload;
  end

  always_comb begin
    status_view                      = '0;
    status_view[ST_SR_BIT]           = (state == SSR_SELF);
    status_view[ST_WOKEN_BIT]        = (state == SSR_WOKEN);
    status_view[ST_CNT_MSB:ST_CNT_LSB] = idle_cnt;
  end

  assign next_rdata = !reg_rd    ? '0 :
                      ctrl_sel   ? ctrl_view :
                      status_sel ? status_view :
                      '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : ssr_self_refresh_ctrl

// ---- ssr_self_refresh_ctrl_tb.sv ----
/*
  ssr_self_refresh_ctrl_tb: register sequences with expected values.
  assumes: DIV 4, sdram model on the memory side.
*/
`timescale 1ns/10ps
`define CHK(g, e) check(16'(g), 16'(e));
module ssr_self_refresh_ctrl_tb;
  import ssr_pkg::*;
  logic        sys_clk, reset_n, reg_wr, reg_rd, go;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
  logic        req, served, ready, enter, leave, sr_active, in_sr, bad;
  int          checked, mismatches, n, n2, n3;

  ssr_self_refresh_ctrl #(.DIV(4)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_access_req(req), .mem_access_served(served),
    .mem_access_ready(ready), .sr_enter_cmd(enter), .sr_exit_cmd(leave),
    .sr_active(sr_active));
  ssr_sdram_model mem (.sys_clk(sys_clk), .go(go), .mem_access_ready(ready),
    .sr_enter_cmd(enter), .sr_exit_cmd(leave), .mem_access_req(req),
    .mem_access_served(served), .in_sr(in_sr), .bad(bad));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic results;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
  // access, then cycles from served to re-entry
  task automatic acc(input logic meas, output int k);
    int t;
    k = 0;
    t = 0;
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    while (t < 300 && (k == 0 || meas && sr_active !== 1'b1)) begin
      @(negedge sys_clk);
      t++;
      if (k > 0) k++;
      else if (served === 1'b1) k = 1;
    end
    if (k == 0 || meas && sr_active !== 1'b1) begin
      mismatches++;
      results;
    end
  endtask : acc

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, go, reg_addr, reg_wdata} = '0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(CTRL_OFFSET);
    `CHK(d, 16'h0f18)
    `CHK(sr_active, 0)
    rd(16'h1c0a);
    `CHK(d, 0)
    wr(16'h1c0a, 16'h0001);
    `CHK(in_sr, 0)
    wr(CTRL_OFFSET, 16'h021f);
    `CHK(in_sr, 1)
    rd(CTRL_OFFSET);
    `CHK(d, 16'h021e)
    rd(STATUS_OFFSET);
    `CHK(d, 16'h0201)
    wr(CTRL_OFFSET, 16'h021f);
    `CHK(bad, 0)
    acc(1'b1, n2);
    wr(CTRL_OFFSET, 16'h031f);
    acc(1'b1, n3);
    `CHK(n3 - n2, TICK_DIV)
    acc(1'b0, n);
    repeat (8) @(negedge sys_clk);
    `CHK(sr_active, 0)
    acc(1'b1, n);
    `CHK(n, n3)
    wr(CTRL_OFFSET, 16'h011f);
    rd(CTRL_OFFSET);
    `CHK(d, 16'h021e)
    wr(CTRL_OFFSET, 16'h0219);
    acc(1'b0, n);
    repeat (40) @(negedge sys_clk);
    `CHK(sr_active, 0)
    wr(CTRL_OFFSET, 16'h0219);
    `CHK(in_sr, 1)
    wr(CTRL_OFFSET, 16'h0218);
    `CHK(in_sr, 0)
    `CHK(bad, 0)
    results;
  end
endmodule : ssr_self_refresh_ctrl_tb

bind ssr_self_refresh_ctrl ssr_chk #(.DIV(DIV)) chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_access_req(mem_access_req),
  .mem_access_served(mem_access_served), .mem_access_ready(mem_access_ready),
  .sr_enter_cmd(sr_enter_cmd), .sr_exit_cmd(sr_exit_cmd), .sr_active(sr_active));

// ---- ssr_tick_div.sv ----
/*
  ssr_tick_div: divides sys_clk into a one-cycle tick every DIV cycles.
  assumes: synchronous reset copy from the top; restart re-aligns the phase.
*/
`timescale 1ns/10ps
module ssr_tick_div #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] phase;
  logic [CW-1:0] next_phase;
  logic          next_tick;

  ////////////////////////////////////////////////////////////////////////////
  // phase counter
  assign next_phase = (restart || phase == LAST) ? '0 : phase + CW'(1);
  assign next_tick  = !restart && (phase == LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
      tick  <= 1'b0;
    end else begin
      phase <= next_phase;
      tick  <= next_tick;
    end
  end

endmodule : ssr_tick_div
